/* logic_and_bit_op_execute.v */
// Four-phase execute slice for literal/file AND and bit set/clear
//
// Notes on behaviour
// - Upper byte 1011 0101: AND low-byte literal into working register.
// - AND operations update only zero flag: set when result is zero.
// - Literal AND: decode Q1, read literal Q2, compute Q3, write Q4.
// - Top seven bits 0000 101: file AND, bit 8 destination, low byte addr.
// - Destination 0 writes working register; 1 writes the file register.
// - Top five bits 1000 1: bit clear, bits 10..8 position, low byte addr.
// - Bit clear zeroes selected bit, other seven bits kept, written back.
// - Top five bits 1000 0: bit set, bits 10..8 position, low byte addr.
// - Bit set forces selected bit to one, other bits kept, written back.
// - Bit operations touch no status flag except via a status write.
// - Any address 0..255 and any bit position 0..7 are accepted.
`timescale 1ns/100ps
`include "logic_bit_defs.vh"

module logic_and_bit_op_execute (
  input  wire        clk,
  input  wire        srst,
  input  wire [15:0] instr_word,
  input  wire [7:0]  working_register,
  input  wire [7:0]  file_rd_data,
  output reg  [1:0]  phase_q,
  output reg         op_hit_q,
  output reg         file_rd_en_q,
  output reg  [7:0]  file_rd_addr_q,
  output reg         file_wr_en_q,
  output reg  [7:0]  file_wr_addr_q,
  output reg  [7:0]  file_wr_data_q,
  output reg         work_wr_en_q,
  output reg  [7:0]  work_wr_data_q,
  output reg         zero_wr_en_q,
  output reg         zero_val_q
);

  // ----------------------------------------------------------------
  // Decoder outputs for the word presented in Q1
  // ----------------------------------------------------------------
  wire [2:0] dec_class;
  wire [7:0] dec_literal;
  wire [7:0] dec_addr;
  wire       dec_dest_file;
  wire [2:0] dec_bit_sel;

  // ----------------------------------------------------------------
  // Latched instruction state across the cycle
  // ----------------------------------------------------------------
  reg  [2:0] class_q;
  reg  [2:0] class_d;
  reg  [7:0] literal_q;
  reg  [7:0] literal_d;
  reg  [7:0] addr_q;
  reg  [7:0] addr_d;
  reg        dest_file_q;
  reg        dest_file_d;
  reg  [2:0] bit_sel_q;
  reg  [2:0] bit_sel_d;
  reg  [7:0] operand_q;
  reg  [7:0] operand_d;
  reg  [7:0] result_q;
  reg  [7:0] result_d;
  reg        result_zero_q;
  reg        result_zero_d;

  // ----------------------------------------------------------------
  // Next values of the output flops
  // ----------------------------------------------------------------
  reg  [1:0] phase_d;
  reg        op_hit_d;
  reg        file_rd_en_d;
  reg  [7:0] file_rd_addr_d;
  reg        file_wr_en_d;
  reg  [7:0] file_wr_addr_d;
  reg  [7:0] file_wr_data_d;
  reg        work_wr_en_d;
  reg  [7:0] work_wr_data_d;
  reg        zero_wr_en_d;
  reg        zero_val_d;

  // One-hot mask of the selected bit position
  wire [7:0] bit_mask;

  // ----------------------------------------------------------------
  // Decoder instance
  // ----------------------------------------------------------------
  op_decode u_op_decode (
    .instr_word (instr_word),
    .op_class   (dec_class),
    .literal    (dec_literal),
    .file_addr  (dec_addr),
    .dest_file  (dec_dest_file),
    .bit_sel    (dec_bit_sel)
  );

  // ----------------------------------------------------------------
  // Bit position mask
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_mask
      // Every position 0..7 reachable
      // Compared at genvar width, no select of the genvar itself
      assign bit_mask[gi] = ({29'h0000000, bit_sel_q} == gi);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Phase sequencing and decode capture
  // ----------------------------------------------------------------
  always @* begin
    phase_d        = phase_q + 2'h1;
    class_d        = class_q;
    literal_d      = literal_q;
    addr_d         = addr_q;
    dest_file_d    = dest_file_q;
    bit_sel_d      = bit_sel_q;
    op_hit_d       = op_hit_q;
    file_rd_en_d   = 1'b0;
    file_rd_addr_d = file_rd_addr_q;
    case (phase_q)
      `PH_Q1: begin
        // Decode: latch class and fields, present read address
        class_d        = dec_class;
        literal_d      = dec_literal;
        addr_d         = dec_addr;
        dest_file_d    = dec_dest_file;
        bit_sel_d      = dec_bit_sel;
        op_hit_d       = (dec_class != `OPC_NONE);
        file_rd_addr_d = dec_addr;
        file_rd_en_d   = (dec_class == `OPC_AND_FILE) ||
                         (dec_class == `OPC_BIT_CLR)  ||
                         (dec_class == `OPC_BIT_SET);
      end
      `PH_Q2: begin
        file_rd_en_d   = 1'b0;
      end
      `PH_Q3: begin
        file_rd_en_d   = 1'b0;
      end
      `PH_Q4: begin
        // Instruction cycle ends, hit flag drops
        op_hit_d       = 1'b0;
      end
      default: begin
        phase_d        = `PH_Q1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Operand fetch in Q2
  // ----------------------------------------------------------------
  always @* begin
    operand_d = operand_q;
    if (phase_q == `PH_Q2) begin
      if (class_q == `OPC_AND_LIT)
        operand_d = literal_q;
      else
        operand_d = file_rd_data;
    end
  end

  // ----------------------------------------------------------------
  // Execute in Q3
  // ----------------------------------------------------------------
  always @* begin
    result_d      = result_q;
    result_zero_d = result_zero_q;
    if (phase_q == `PH_Q3) begin
      case (class_q)
        `OPC_AND_LIT: begin
          result_d = working_register & operand_q;
        end
        `OPC_AND_FILE: begin
          result_d = working_register & operand_q;
        end
        `OPC_BIT_CLR: begin
          result_d = operand_q & ~bit_mask;
        end
        `OPC_BIT_SET: begin
          result_d = operand_q | bit_mask;
        end
        default: begin
          result_d = `BYTE_RST;
        end
      endcase
      result_zero_d = (result_d == `BYTE_RST);
    end
  end

  // ----------------------------------------------------------------
  // Destination write strobes, launched for Q4
  // ----------------------------------------------------------------
  always @* begin
    file_wr_en_d   = 1'b0;
    file_wr_addr_d = file_wr_addr_q;
    file_wr_data_d = file_wr_data_q;
    work_wr_en_d   = 1'b0;
    work_wr_data_d = work_wr_data_q;
    zero_wr_en_d   = 1'b0;
    zero_val_d     = zero_val_q;
    if (phase_q == `PH_Q3) begin
      case (class_q)
        `OPC_AND_LIT: begin
          // Literal result always to working register
          work_wr_en_d   = 1'b1;
          work_wr_data_d = result_d;
          zero_wr_en_d   = 1'b1;
          zero_val_d     = result_zero_d;
        end
        `OPC_AND_FILE: begin
          // Exactly one destination, chosen by d
          work_wr_en_d   = ~dest_file_q;
          work_wr_data_d = result_d;
          file_wr_en_d   = dest_file_q;
          file_wr_addr_d = addr_q;
          file_wr_data_d = result_d;
          zero_wr_en_d   = 1'b1;
          zero_val_d     = result_zero_d;
        end
        `OPC_BIT_CLR: begin
          // Write back, flags untouched
          // A status target changes only through this write
          file_wr_en_d   = 1'b1;
          file_wr_addr_d = addr_q;
          file_wr_data_d = result_d;
          zero_wr_en_d   = 1'b0;
        end
        `OPC_BIT_SET: begin
          // Write back, flags untouched
          file_wr_en_d   = 1'b1;
          file_wr_addr_d = addr_q;
          file_wr_data_d = result_d;
          zero_wr_en_d   = 1'b0;
        end
        default: begin
          file_wr_en_d   = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Internal state flops
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      class_q       <= `OPC_NONE;
      literal_q     <= `BYTE_RST;
      addr_q        <= `ADDR_RST;
      dest_file_q   <= 1'b0;
      bit_sel_q     <= 3'h0;
      operand_q     <= `BYTE_RST;
      result_q      <= `BYTE_RST;
      result_zero_q <= 1'b0;
    end else begin
      class_q       <= class_d;
      literal_q     <= literal_d;
      addr_q        <= addr_d;
      dest_file_q   <= dest_file_d;
      bit_sel_q     <= bit_sel_d;
      operand_q     <= operand_d;
      result_q      <= result_d;
      result_zero_q <= result_zero_d;
    end
  end

  // ----------------------------------------------------------------
  // Output flops
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      phase_q        <= `PH_Q1;
      op_hit_q       <= 1'b0;
      file_rd_en_q   <= 1'b0;
      file_rd_addr_q <= `ADDR_RST;
      file_wr_en_q   <= 1'b0;
      file_wr_addr_q <= `ADDR_RST;
      file_wr_data_q <= `BYTE_RST;
      work_wr_en_q   <= 1'b0;
      work_wr_data_q <= `BYTE_RST;
      zero_wr_en_q   <= 1'b0;
      zero_val_q     <= 1'b0;
    end else begin
      phase_q        <= phase_d;
      op_hit_q       <= op_hit_d;
      file_rd_en_q   <= file_rd_en_d;
      file_rd_addr_q <= file_rd_addr_d;
      file_wr_en_q   <= file_wr_en_d;
      file_wr_addr_q <= file_wr_addr_d;
      file_wr_data_q <= file_wr_data_d;
      work_wr_en_q   <= work_wr_en_d;
      work_wr_data_q <= work_wr_data_d;
      zero_wr_en_q   <= zero_wr_en_d;
      zero_val_q     <= zero_val_d;
    end
  end

endmodule

/* logic_bit_defs.vh */
// Constants for the logic AND and bit set/clear execute slice
`ifndef LOGIC_BIT_DEFS_VH
`define LOGIC_BIT_DEFS_VH

// ----------------------------------------------------------------
// Opcode patterns
// ----------------------------------------------------------------
`define AND_LIT_OPC      8'hB5
`define AND_FILE_OPC     7'h05
`define BIT_CLR_OPC      5'h11
`define BIT_SET_OPC      5'h10

// ----------------------------------------------------------------
// Instruction word field positions
// ----------------------------------------------------------------
`define LIT_MSB          7
`define ADDR_MSB         7
`define DEST_BIT         8
`define BITSEL_MSB       10
`define BITSEL_LSB       8

// ----------------------------------------------------------------
// Operation classes
// ----------------------------------------------------------------
`define OPC_NONE         3'h0
`define OPC_AND_LIT      3'h1
`define OPC_AND_FILE     3'h2
`define OPC_BIT_CLR      3'h3
`define OPC_BIT_SET      3'h4

// ----------------------------------------------------------------
// Phases of one instruction cycle
// ----------------------------------------------------------------
`define PH_Q1            2'h0
`define PH_Q2            2'h1
`define PH_Q3            2'h2
`define PH_Q4            2'h3
`define PHASES_PER_CYCLE 4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define BYTE_RST         8'h00
`define ADDR_RST         8'h00

`endif

/* op_decode.v */
// Opcode matcher and operand field extractor
`timescale 1ns/100ps
`include "logic_bit_defs.vh"

module op_decode (
  input  wire [15:0] instr_word,
  output wire [2:0]  op_class,
  output wire [7:0]  literal,
  output wire [7:0]  file_addr,
  output wire        dest_file,
  output wire [2:0]  bit_sel
);

  // ----------------------------------------------------------------
  // Classify a word into one of the four operations, or none if no pattern matches
  // ----------------------------------------------------------------
  function [2:0] classify;
    input [15:0] w;
    begin
      if (w[15:8] == `AND_LIT_OPC)
        classify = `OPC_AND_LIT;
      else if (w[15:9] == `AND_FILE_OPC)
        classify = `OPC_AND_FILE;
      else if (w[15:11] == `BIT_CLR_OPC)
        classify = `OPC_BIT_CLR;
      else if (w[15:11] == `BIT_SET_OPC)
        classify = `OPC_BIT_SET;
      else
        classify = `OPC_NONE;
    end
  endfunction

  // Operand fields, full 8-bit address and 3-bit position
  assign op_class  = classify(instr_word);
  assign literal   = instr_word[`LIT_MSB:0];
  assign file_addr = instr_word[`ADDR_MSB:0];
  assign dest_file = instr_word[`DEST_BIT];
  assign bit_sel   = instr_word[`BITSEL_MSB:`BITSEL_LSB];

endmodule

/* logic_and_bit_op_execute_props.sv */
// Assertion checker for the logic AND and bit set/clear execute slice
`timescale 1ns/100ps
`include "logic_bit_defs.vh"

module exec_props (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [15:0] instr_word,
  input wire logic [7:0]  working_register,
  input wire logic [7:0]  file_rd_data,
  input wire logic [1:0]  phase_q,
  input wire logic        op_hit_q,
  input wire logic        file_rd_en_q,
  input wire logic [7:0]  file_rd_addr_q,
  input wire logic        file_wr_en_q,
  input wire logic [7:0]  file_wr_addr_q,
  input wire logic [7:0]  file_wr_data_q,
  input wire logic        work_wr_en_q,
  input wire logic [7:0]  work_wr_data_q,
  input wire logic        zero_wr_en_q,
  input wire logic        zero_val_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ----------------------------------------------------------------
  // Decoded takes and operation steps
  // ----------------------------------------------------------------
  wire tk    = phase_q == `PH_Q1;
  wire lit_t = tk && instr_word[15:8] == `AND_LIT_OPC;
  wire fil_t = tk && instr_word[15:9] == `AND_FILE_OPC;
  wire bit_t = tk && instr_word[15:12] == 4'h8;
  sequence rd_s;
    file_rd_en_q && file_rd_addr_q == $past(instr_word[7:0]);
  endsequence
  sequence lit_wr_s;
    work_wr_en_q && zero_wr_en_q && !file_wr_en_q &&
    work_wr_data_q == ($past(instr_word[7:0], 3) & $past(working_register));
  endsequence
  sequence fil_wr_s;
    zero_wr_en_q && ($past(instr_word[8], 3) ?
      (file_wr_en_q && !work_wr_en_q && file_wr_data_q ==
       ($past(working_register) & $past(file_rd_data, 2))) :
      (work_wr_en_q && !file_wr_en_q && work_wr_data_q ==
       ($past(working_register) & $past(file_rd_data, 2))));
  endsequence
  sequence bit_wr_s;
    file_wr_en_q && !work_wr_en_q && !zero_wr_en_q &&
    file_wr_addr_q == $past(instr_word[7:0], 3);
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  phase_step_a: assert property (phase_q != `PH_Q4 |=>
    phase_q == $past(phase_q) + 2'h1) else $error("phase did not advance");
  phase_wrap_a: assert property (phase_q == `PH_Q4 |=>
    phase_q == `PH_Q1) else $error("phase did not wrap");
  lit_and_a: assert property (lit_t |-> ##3 lit_wr_s)
    else $error("literal AND result wrong");
  file_and_a: assert property (fil_t |-> ##1 rd_s ##2 fil_wr_s)
    else $error("file AND result or destination wrong");
  bit_op_a: assert property (bit_t |-> ##1 rd_s ##2 bit_wr_s)
    else $error("bit operation write wrong");
  file_wr_q4_a: assert property (file_wr_en_q |-> phase_q == `PH_Q4)
    else $error("file write outside last phase");
  w_wr_q4_a: assert property (work_wr_en_q |-> phase_q == `PH_Q4)
    else $error("working write outside last phase");
  read_q2_a: assert property (file_rd_en_q |->
    phase_q == `PH_Q2 && op_hit_q) else $error("file read outside Q2");
  zero_val_a: assert property (zero_wr_en_q |-> zero_val_q ==
    ((file_wr_en_q ? file_wr_data_q : work_wr_data_q) == 8'h00))
    else $error("zero flag value wrong");
  no_hit_a: assert property (tk && !lit_t && !fil_t && !bit_t |=>
    !op_hit_q [*3]) else $error("unknown word was executed");
endmodule

bind logic_and_bit_op_execute exec_props u_props (
  .clk(clk), .srst(srst), .instr_word(instr_word),
  .working_register(working_register), .file_rd_data(file_rd_data),
  .phase_q(phase_q), .op_hit_q(op_hit_q), .file_rd_en_q(file_rd_en_q),
  .file_rd_addr_q(file_rd_addr_q), .file_wr_en_q(file_wr_en_q),
  .file_wr_addr_q(file_wr_addr_q), .file_wr_data_q(file_wr_data_q),
  .work_wr_en_q(work_wr_en_q), .work_wr_data_q(work_wr_data_q),
  .zero_wr_en_q(zero_wr_en_q), .zero_val_q(zero_val_q));

/* test_logic_and_bit_op_execute.sv */
// Self-checking testbench for the logic AND and bit set/clear slice
`timescale 1ns/100ps
`include "logic_bit_defs.vh"

module test_logic_and_bit_op_execute;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [15:0] instr_word = 16'h0000;
  logic [7:0]  working_register = 8'h00;
  logic [7:0]  file_rd_data = 8'h00;
  wire  [1:0]  phase_q;
  wire         op_hit_q, file_rd_en_q, file_wr_en_q, work_wr_en_q;
  wire         zero_wr_en_q, zero_val_q;
  wire  [7:0]  file_rd_addr_q, file_wr_addr_q, file_wr_data_q;
  wire  [7:0]  work_wr_data_q;
  int          bad_count = 0;
  int          samples_checked = 0;
  logic        hit, rd_en, wr_en, we_w, z_en, z_val;
  logic [7:0]  rd_addr, wr_addr, wr_data, w_data;

  logic_and_bit_op_execute uut (
    .clk(clk), .srst(srst), .instr_word(instr_word),
    .working_register(working_register), .file_rd_data(file_rd_data),
    .phase_q(phase_q), .op_hit_q(op_hit_q), .file_rd_en_q(file_rd_en_q),
    .file_rd_addr_q(file_rd_addr_q), .file_wr_en_q(file_wr_en_q),
    .file_wr_addr_q(file_wr_addr_q), .file_wr_data_q(file_wr_data_q),
    .work_wr_en_q(work_wr_en_q), .work_wr_data_q(work_wr_data_q),
    .zero_wr_en_q(zero_wr_en_q), .zero_val_q(zero_val_q));

  // Core clock, 25 ns period
  always #12.5 clk = ~clk;

  task automatic check(input string nm, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One instruction cycle; operands turn stale outside their phase
  task automatic exec(input logic [15:0] word, input logic [7:0] w, f);
    int n;
    n = 0;
    @(negedge clk);
    while (phase_q !== `PH_Q1) begin
      @(negedge clk);
      n++;
      if (n > 8) begin
        bad_count++;
        end_of_test();
      end
    end
    instr_word = word;
    working_register = w;
    file_rd_data = f;
    @(negedge clk);
    instr_word = 16'hFFFF;
    hit = op_hit_q;
    rd_en = file_rd_en_q;
    rd_addr = file_rd_addr_q;
    @(negedge clk);
    file_rd_data = ~f;
    @(negedge clk);
    working_register = ~w;
    check("phase", phase_q, `PH_Q4);
    {wr_en, wr_addr, wr_data} = {file_wr_en_q, file_wr_addr_q, file_wr_data_q};
    {we_w, w_data, z_en, z_val} =
      {work_wr_en_q, work_wr_data_q, zero_wr_en_q, zero_val_q};
  endtask

  // Compare the captured strobes and values with the expected outcome
  task automatic verify(input logic ren, fwe, wwe, zwe,
                        input logic [7:0] a, d, input logic z);
    check("read_en", rd_en, ren);
    check("file_wr_en", wr_en, fwe);
    check("w_wr_en", we_w, wwe);
    check("zero_wr_en", z_en, zwe);
    check("op_hit", hit, ren | wwe);
    if (ren) check("read_addr", rd_addr, a);
    if (fwe) check("file_wr_addr", wr_addr, a);
    if (fwe) check("file_wr_data", wr_data, d);
    if (wwe) check("w_wr_data", w_data, d);
    if (zwe) check("zero_val", z_val, z);
  endtask

  task automatic t_and_lit;
    exec({`AND_LIT_OPC, 8'h5F}, 8'hA3, 8'h00);
    verify(0, 0, 1, 1, 8'h00, 8'h03, 0);
    exec({`AND_LIT_OPC, 8'h0F}, 8'hF0, 8'hFF);
    verify(0, 0, 1, 1, 8'h00, 8'h00, 1);
    $display("test and_literal done");
  endtask

  task automatic t_and_file;
    exec({`AND_FILE_OPC, 1'b1, 8'h80}, 8'h17, 8'hC2);
    verify(1, 1, 0, 1, 8'h80, 8'h02, 0);
    exec({`AND_FILE_OPC, 1'b0, 8'hFF}, 8'h17, 8'hC2);
    verify(1, 0, 1, 1, 8'hFF, 8'h02, 0);
    exec({`AND_FILE_OPC, 1'b1, 8'h00}, 8'h0F, 8'hF0);
    verify(1, 1, 0, 1, 8'h00, 8'h00, 1);
    $display("test and_file done");
  endtask

  task automatic t_bit_ops;
    logic [7:0] a, f, e;
    for (int op = 0; op < 2; op++) begin
      for (int b = 0; b < 8; b++) begin
        a = (b == 7) ? 8'hFF : 8'(b * 36);
        f = op ? 8'h0A : 8'hC7;
        e = op ? (f | (8'h01 << b)) : (f & ~(8'h01 << b));
        exec({op ? `BIT_SET_OPC : `BIT_CLR_OPC, 3'(b), a}, 8'h00, f);
        verify(1, 1, 0, 0, a, e, 0);
      end
    end
    $display("test bit_ops done");
  endtask

  task automatic t_ignored;
    logic [15:0] ws [3];
    ws = '{16'hB400, 16'h0C00, 16'h9000};
    for (int i = 0; i < 3; i++) begin
      exec(ws[i], 8'h00, 8'h00);
      verify(0, 0, 0, 0, 8'h00, 8'h00, 0);
    end
    $display("test ignored_words done");
  endtask

  // Two reset edges, then phase at Q1 and write strobes low
  task automatic t_reset;
    repeat (2) @(negedge clk);
    check("reset_phase", phase_q, `PH_Q1);
    check("reset_wr_en", file_wr_en_q, 1'b0);
    check("reset_w_en", work_wr_en_q, 1'b0);
    srst = 1'b0;
    $display("test reset done");
  endtask

  // Reset, then the scenarios back to back
  initial begin
    t_reset();
    t_and_lit();
    t_and_file();
    t_bit_ops();
    t_ignored();
    end_of_test();
  end
endmodule
